/* hw/timer_pkg.sv */
package timer_pkg;

  // Register byte offsets on the bus.
  localparam logic [7:0] OFF_CONTROL_A = 8'h00;
  localparam logic [7:0] OFF_CONTROL_B = 8'h04;
  localparam logic [7:0] OFF_COUNT = 8'h08;
  localparam logic [7:0] OFF_COMPARE_A = 8'h0c;
  localparam logic [7:0] OFF_COMPARE_B = 8'h10;
  localparam logic [7:0] OFF_FLAG = 8'h14;
  localparam logic [7:0] OFF_MASK = 8'h18;
  localparam logic [7:0] OFF_POWER = 8'h1c;

  // Field positions.
  localparam int WAVE_LO_POS = 0;
  localparam int WAVE_HI_POS = 3;
  localparam int CLOCK_SEL_POS = 0;
  localparam int POWER_OFF_POS = 0;
  localparam int FLAG_OVF = 0;
  localparam int FLAG_CMP_A = 1;
  localparam int FLAG_CMP_B = 2;

  // Reset values.
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] COMPARE_RESET = 8'h00;
  localparam logic [2:0] FIELD_RESET = 3'h0;

  // Counter landmarks and step.
  localparam logic [7:0] BOTTOM = 8'h00;
  localparam logic [7:0] MAX = 8'hff;
  localparam logic [7:0] COUNT_STEP = 8'h01;

  // Waveform modes.
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_PC_FF = 3'h1;
  localparam logic [2:0] MODE_CTC = 3'h2;
  localparam logic [2:0] MODE_FAST_FF = 3'h3;
  localparam logic [2:0] MODE_PC_OCRA = 3'h5;
  localparam logic [2:0] MODE_FAST_OCRA = 3'h7;

  // Clock select codes and prescaler tap widths.
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam int PRESCALE_W = 10;
  localparam int TAP_DIV8 = 3;
  localparam int TAP_DIV64 = 6;
  localparam int TAP_DIV256 = 8;

  localparam logic [1:0] RESP_OKAY = 2'h0;

  // True for modes whose top comes from compare register A.
  function automatic logic uses_ocra_top(input logic [2:0] mode);
    return (mode == MODE_CTC) || (mode == MODE_PC_OCRA) || (mode == MODE_FAST_OCRA);
  endfunction

  // True for modes whose compare registers are double buffered.
  function automatic logic is_pwm(input logic [2:0] mode);
    return (mode == MODE_PC_FF) || (mode == MODE_FAST_FF) || (mode == MODE_PC_OCRA) ||
      (mode == MODE_FAST_OCRA);
  endfunction

endpackage

/* hw/tick_if.sv */
`timescale 1ns/1ps
// Carries the tick request and the resulting timer tick.
interface tick_if;
  logic [2:0] clock_select;
  logic enable;
  logic tick;
  modport sel (input clock_select, input enable, output tick);
  modport core (output clock_select, output enable, input tick);
endinterface

/* hw/tick_select.sv */
`timescale 1ns/1ps
module tick_select
  import timer_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ext_pin_i,
  tick_if.sel tif
);

  logic [PRESCALE_W-1:0] prescale;
  logic [2:0] sync;
  logic stable;
  logic prev_stable;
  logic sel_tick;

  // Free running prescaler; each tap gives a one-cycle enable pulse.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      prescale <= '0;
    else
      prescale <= PRESCALE_W'(prescale + 1'b1);
  end

  // The pin passes three flops; a level counts once the last two agree.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sync <= 3'h0;
      stable <= 1'b0;
      prev_stable <= 1'b0;
    end
    else
    begin
      sync <= {sync[1:0], ext_pin_i};
      if (sync[1] == sync[2])
        stable <= sync[2];
      prev_stable <= stable;
    end
  end

  // Source and edge choice; code zero gives no tick at all.
  always_comb
  begin
    case (tif.clock_select)
      CS_STOP: sel_tick = 1'b0;
      CS_DIV1: sel_tick = 1'b1;
      CS_DIV8: sel_tick = &prescale[TAP_DIV8-1:0];
      CS_DIV64: sel_tick = &prescale[TAP_DIV64-1:0];
      CS_DIV256: sel_tick = &prescale[TAP_DIV256-1:0];
      CS_DIV1024: sel_tick = &prescale;
      CS_EXT_FALL: sel_tick = prev_stable && !stable;
      CS_EXT_RISE: sel_tick = stable && !prev_stable;
      default: sel_tick = 1'b0;
    endcase
  end

  // A powered-down timer sees no tick.
  assign tif.tick = tif.enable && sel_tick;

endmodule

/* hw/compare_unit.sv */
`timescale 1ns/1ps
module compare_unit
  import timer_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic write_i,
  input wire logic [7:0] data_i,
  input wire logic buffered_i,
  input wire logic update_i,
  input wire logic [7:0] count_i,
  output logic [7:0] buffer_o,
  output logic [7:0] active_o,
  output logic match_o
);

  // Software writes the buffer; the active value follows it directly
  // unless buffering is on, then only at the update pulse.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      buffer_o <= COMPARE_RESET;
      active_o <= COMPARE_RESET;
    end
    else
    begin
      if (write_i)
        buffer_o <= data_i;
      if (write_i && !buffered_i)
        active_o <= data_i;
      else if (update_i)
        active_o <= buffer_o;
    end
  end

  // The comparison runs every cycle.
  assign match_o = (active_o == count_i);

endmodule

/* hw/timer_core.sv */
// Implementation choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
// How it works
// - Clock select zero gives no tick, so the counter holds.
// - A software count write beats any clear or step in that cycle.
// - Software reads and writes the count at any time.
// - Bottom indication is high while the count is zero.
// - Max indication is high while the count is all ones.
// - Top is all ones or compare A, chosen by the mode.
// - Count and both compare registers are eight bits wide.
// - All three request flags read back in the flag register.
// - Each flag has a mask bit; only unmasked flags raise the request.
// - The tick comes from the prescaler or from the external pin.
// - Clock select picks the source and the external edge.
// - Both compare values are checked against the count every cycle.
// - A match on unit A or B sets that unit's flag.
// - On each tick the counter clears, rises or falls per mode.
// - Mode field: two low bits in control A, high bit in control B.
// - The overflow flag's condition depends on the mode.
// - The timer runs only while the power-off bit is zero.
// - Three interrupt sources: overflow, compare A, compare B.
// - Two compare units, each with a double-buffered register.
// - A count step changes the value by exactly one, up or down.
// - A clear sets every counter bit to zero.
// - Top and bottom indications follow the counter value.
// - Normal mode counts up, wraps to zero and sets overflow then.
// - CTC mode clears at compare A, which acts as top.
module timer_core
  import timer_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic RESET_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  input wire logic EXT_COUNT_PIN_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic [1:0] HRESP_O,
  output logic IRQ_O,
  output logic BOTTOM_O,
  output logic MAX_O,
  output logic TOP_O,
  output logic MATCH_A_O,
  output logic MATCH_B_O
);

  logic pend;
  logic pend_write;
  logic [7:0] pend_addr;
  logic wr;
  logic [7:0] wdata;
  logic cnt_wr;
  logic [7:0] count;
  logic [7:0] next_count;
  logic dir_down;
  logic next_dir_down;
  logic ovf_hit;
  logic [1:0] wave_lo;
  logic wave_hi;
  logic [2:0] clock_select;
  logic [2:0] mode;
  logic [2:0] flags;
  logic [2:0] mask;
  logic [2:0] flag_set;
  logic [2:0] flag_clear;
  logic power_off;
  logic blocked;
  logic tick;
  logic [7:0] top_value;
  logic at_top;
  logic cmp_update;
  logic [1:0] cmp_wr;
  logic [1:0] cmp_match;
  logic [1:0][7:0] cmp_buf;
  logic [1:0][7:0] cmp_act;
  logic [31:0] read_word;

  // True when a latched address selects the given register.
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
    return addr == offset;
  endfunction

  tick_if tif ();

  // A write lands in the data phase, the wait cycle after the address phase.
  assign wr = pend && pend_write;
  assign wdata = HWDATA_I[7:0];
  assign cnt_wr = wr && hit(pend_addr, OFF_COUNT);
  assign mode = {wave_hi, wave_lo};
  assign tif.clock_select = clock_select;
  assign tif.enable = !power_off;
  assign tick = tif.tick;

  tick_select u_tick (
    .clk_i(CORE_CLK_I),
    .rst_i(RESET_I),
    .ext_pin_i(EXT_COUNT_PIN_I),
    .tif(tif.sel)
  );

  // Top is all ones or the active compare A value.
  assign top_value = uses_ocra_top(mode) ? cmp_act[0] : MAX;
  assign at_top = (count == top_value);
  // Buffered compare values move to the active side at top.
  assign cmp_update = tick && !cnt_wr && at_top && is_pwm(mode);

  // Two compare units, A at index zero and B at index one.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_cmp
      assign cmp_wr[gi] = wr && hit(pend_addr, (gi == 0) ? OFF_COMPARE_A : OFF_COMPARE_B);
      compare_unit u_cmp (
        .clk_i(CORE_CLK_I),
        .rst_i(RESET_I),
        .write_i(cmp_wr[gi]),
        .data_i(wdata),
        .buffered_i(is_pwm(mode)),
        .update_i(cmp_update),
        .count_i(count),
        .buffer_o(cmp_buf[gi]),
        .active_o(cmp_act[gi]),
        .match_o(cmp_match[gi])
      );
    end
  endgenerate

  // Read multiplexer; unmapped addresses read as zero.
  always_comb
  begin
    read_word = 32'h0;
    case (pend_addr)
      OFF_CONTROL_A: read_word[WAVE_LO_POS +: 2] = wave_lo;
      OFF_CONTROL_B:
      begin
        read_word[CLOCK_SEL_POS +: 3] = clock_select;
        read_word[WAVE_HI_POS] = wave_hi;
      end
      OFF_COUNT: read_word[7:0] = count;
      OFF_COMPARE_A: read_word[7:0] = cmp_buf[0];
      OFF_COMPARE_B: read_word[7:0] = cmp_buf[1];
      OFF_FLAG: read_word[2:0] = flags;
      OFF_MASK: read_word[2:0] = mask;
      OFF_POWER: read_word[POWER_OFF_POS] = power_off;
      default: read_word = 32'h0;
    endcase
  end

  // Bus slave: one wait cycle per transfer, always an OKAY response.
  always_ff @(posedge CORE_CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      pend <= 1'b0;
      pend_write <= 1'b0;
      pend_addr <= 8'h00;
      HREADYOUT_O <= 1'b1;
      HRDATA_O <= 32'h0;
      HRESP_O <= RESP_OKAY;
    end
    else
    begin
      HRESP_O <= RESP_OKAY;
      if (pend)
      begin
        pend <= 1'b0;
        HREADYOUT_O <= 1'b1;
        HRDATA_O <= pend_write ? 32'h0 : read_word;
      end
      else if (HSEL_I && HTRANS_I[1] && HREADY_I)
      begin
        pend <= 1'b1;
        pend_write <= HWRITE_I;
        pend_addr <= HADDR_I[7:0];
        HREADYOUT_O <= 1'b0;
      end
    end
  end

  // Control fields, mask and power bit written by software.
  always_ff @(posedge CORE_CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      wave_lo <= FIELD_RESET[1:0];
      wave_hi <= FIELD_RESET[0];
      clock_select <= FIELD_RESET;
      mask <= FIELD_RESET;
      power_off <= FIELD_RESET[0];
    end
    else if (wr)
    begin
      if (hit(pend_addr, OFF_CONTROL_A))
        wave_lo <= wdata[WAVE_LO_POS +: 2];
      if (hit(pend_addr, OFF_CONTROL_B))
      begin
        wave_hi <= wdata[WAVE_HI_POS];
        clock_select <= wdata[CLOCK_SEL_POS +: 3];
      end
      if (hit(pend_addr, OFF_MASK))
        mask <= wdata[2:0];
      if (hit(pend_addr, OFF_POWER))
        power_off <= wdata[POWER_OFF_POS];
    end
  end

  // Next count: a software write first, otherwise the mode's step on a tick.
  always_comb
  begin
    next_count = count;
    next_dir_down = dir_down;
    ovf_hit = 1'b0;
    if (cnt_wr)
      next_count = wdata;
    else if (tick)
    begin
      case (mode)
        MODE_PC_FF, MODE_PC_OCRA:
        begin
          if (!dir_down && at_top)
          begin
            next_dir_down = 1'b1;
            next_count = 8'(count - COUNT_STEP);
          end
          else if (dir_down && count == BOTTOM)
          begin
            next_dir_down = 1'b0;
            next_count = 8'(count + COUNT_STEP);
            ovf_hit = 1'b1;
          end
          else if (dir_down)
            next_count = 8'(count - COUNT_STEP);
          else
            next_count = 8'(count + COUNT_STEP);
        end
        MODE_CTC, MODE_FAST_FF, MODE_FAST_OCRA:
        begin
          next_dir_down = 1'b0;
          next_count = at_top ? BOTTOM : 8'(count + COUNT_STEP);
          ovf_hit = (mode == MODE_CTC) ? (count == MAX) : at_top;
        end
        default:
        begin
          next_dir_down = 1'b0;
          next_count = 8'(count + COUNT_STEP);
          ovf_hit = (count == MAX);
        end
      endcase
    end
  end

  // Counter register with its landmark indications taken from the next value.
  always_ff @(posedge CORE_CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      count <= COUNT_RESET;
      dir_down <= 1'b0;
      BOTTOM_O <= 1'b1;
      MAX_O <= 1'b0;
      TOP_O <= 1'b0;
    end
    else
    begin
      count <= next_count;
      dir_down <= next_dir_down;
      BOTTOM_O <= (next_count == BOTTOM);
      MAX_O <= (next_count == MAX);
      TOP_O <= (next_count == top_value);
    end
  end

  // A count write blocks compare matches until the next tick has passed.
  always_ff @(posedge CORE_CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
      blocked <= 1'b0;
    else if (cnt_wr)
      blocked <= 1'b1;
    else if (tick)
      blocked <= 1'b0;
  end

  // Flag sources; a match is taken on the tick that leaves the matching value.
  assign flag_set[FLAG_OVF] = ovf_hit;
  assign flag_set[FLAG_CMP_A] = tick && !cnt_wr && !blocked && cmp_match[0];
  assign flag_set[FLAG_CMP_B] = tick && !cnt_wr && !blocked && cmp_match[1];
  assign flag_clear = (wr && hit(pend_addr, OFF_FLAG)) ? wdata[2:0] : 3'h0;

  // Sticky flags cleared by writing one; a set in the same cycle wins.
  always_ff @(posedge CORE_CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
      flags <= FIELD_RESET;
    else
      flags <= (flags & ~flag_clear) | flag_set;
  end

  // Registered request and match outputs.
  always_ff @(posedge CORE_CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      IRQ_O <= 1'b0;
      MATCH_A_O <= 1'b0;
      MATCH_B_O <= 1'b0;
    end
    else
    begin
      IRQ_O <= |(flags & mask);
      MATCH_A_O <= cmp_match[0];
      MATCH_B_O <= cmp_match[1];
    end
  end

  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (RESET_I);

  stopped_hold_a: assert property (clock_select == CS_STOP && !cnt_wr |=> $stable(count))
    else $error("Counter moved while stopped.");

  write_wins_a: assert property (cnt_wr |=> count == $past(HWDATA_I[7:0]))
    else $error("Count write did not take priority.");

  bottom_ind_a: assert property (BOTTOM_O == (count == BOTTOM))
    else $error("Bottom indication wrong.");

  max_ind_a: assert property (MAX_O == (count == MAX))
    else $error("Max indication wrong.");

  normal_wrap_a: assert property (tick && !cnt_wr && mode == MODE_NORMAL && count == MAX
    |=> count == BOTTOM && flags[FLAG_OVF])
    else $error("Normal mode wrap or overflow missing.");

  ctc_clear_a: assert property (tick && !cnt_wr && mode == MODE_CTC && count == cmp_act[0]
    |=> count == BOTTOM)
    else $error("CTC clear missing.");

  step_one_a: assert property (tick && !cnt_wr && mode == MODE_NORMAL && count != MAX
    |=> count == 8'($past(count) + COUNT_STEP))
    else $error("Count step not one.");

  irq_gate_a: assert property (IRQ_O == $past(|(flags & mask)))
    else $error("Interrupt not gated by mask.");

  match_flag_a: assert property (flag_set[FLAG_CMP_A] |=> flags[FLAG_CMP_A] ##1
    (flags[FLAG_CMP_A] || $past(flag_clear[FLAG_CMP_A])))
    else $error("Compare flag A not set.");

  power_gate_a: assert property (power_off && !cnt_wr |=> $stable(count))
    else $error("Counter moved while powered off.");

  ovf_cover: cover property (flag_set[FLAG_OVF]);
  match_b_cover: cover property (flag_set[FLAG_CMP_B] && mask[FLAG_CMP_B]);
  ctc_cover: cover property (tick && mode == MODE_CTC && at_top);
  turn_cover: cover property (tick && mode == MODE_PC_FF && !dir_down && at_top);

endmodule

/* test/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import timer_pkg::*;
  typedef struct {logic [7:0] addr; logic [31:0] wdata; logic [31:0] exp;} row_t;
  logic clk;
  logic rst;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic ext_pin;
  logic [31:0] hrdata;
  logic hreadyout;
  logic [1:0] hresp;
  logic irq;
  logic bottom;
  logic max_hit;
  logic top;
  logic match_a;
  logic match_b;
  int failures;
  int samples_checked;
  logic [31:0] rdata;
  row_t rows[9];

  // The single slave's ready output closes the bus ready loop.
  timer_core i_dut (
    .CORE_CLK_I(clk), .RESET_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata),
    .HREADY_I(hreadyout), .EXT_COUNT_PIN_I(ext_pin), .HRDATA_O(hrdata),
    .HREADYOUT_O(hreadyout), .HRESP_O(hresp), .IRQ_O(irq), .BOTTOM_O(bottom),
    .MAX_O(max_hit), .TOP_O(top), .MATCH_A_O(match_a), .MATCH_B_O(match_b)
  );

  // Free running 200 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Compares one value and counts the outcome.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, got, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("failures %0d, samples_checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // One single-word bus transfer; waits on ready with a bounded guard.
  task automatic xfer(input logic wr_en, input logic [7:0] addr, input logic [31:0] wdata,
    output logic [31:0] got);
    int guard;
    guard = 0;
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, addr};
    hwrite <= wr_en;
    @(posedge clk);
    while (hreadyout !== 1'b1 && guard < 50)
    begin
      @(posedge clk);
      guard++;
    end
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wdata;
    @(posedge clk);
    while (hreadyout !== 1'b1 && guard < 100)
    begin
      @(posedge clk);
      guard++;
    end
    got = hrdata;
    check(hreadyout, 32'h1);
    check(hresp, RESP_OKAY);
  endtask

  task automatic wr(input logic [7:0] addr, input logic [31:0] wdata);
    logic [31:0] dummy;
    xfer(1'b1, addr, wdata, dummy);
  endtask

  task automatic rd_check(input logic [7:0] addr, input logic [31:0] exp);
    logic [31:0] got;
    xfer(1'b0, addr, 32'h0, got);
    check(got, exp);
  endtask

  // Full pulses on the external count pin, long enough to pass the synchroniser.
  task automatic pulse(input int n);
    repeat (n)
    begin
      @(posedge clk);
      ext_pin <= 1'b1;
      repeat (8) @(posedge clk);
      ext_pin <= 1'b0;
      repeat (8) @(posedge clk);
    end
  endtask

  // Lets the updates of the last edge land before ports are sampled.
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Opens the power gate for n plus four edges, since each bus write lands two
  // edges after its address phase, then reads how far the count moved.
  task automatic timed_run(input logic [2:0] code, input int n, input logic [31:0] exp);
    wr(OFF_POWER, 32'h1);
    wr(OFF_CONTROL_B, {29'h0, code});
    wr(OFF_COUNT, 32'h0);
    wr(OFF_POWER, 32'h0);
    repeat (n) @(posedge clk);
    wr(OFF_POWER, 32'h1);
    rd_check(OFF_COUNT, exp);
  endtask

  // Cuts a hung run short after far more time than the tests need.
  initial
  begin
    #100000;
    failures++;
    tally_and_finish();
  end

  // Main sequence: register table, then the counting cases by hand.
  initial
  begin
    failures = 0;
    samples_checked = 0;
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    ext_pin = 1'b0;
    rows = '{'{OFF_CONTROL_A, 32'h2, 32'h2}, '{OFF_CONTROL_B, 32'h8, 32'h8},
      '{OFF_COUNT, 32'h5a, 32'h5a}, '{OFF_COMPARE_A, 32'ha5, 32'ha5},
      '{OFF_COMPARE_B, 32'h3c, 32'h3c}, '{OFF_MASK, 32'h7, 32'h7},
      '{OFF_POWER, 32'h1, 32'h1}, '{8'h20, 32'hffffffff, 32'h0},
      '{OFF_COUNT, 32'hffffff81, 32'h81}};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i])
    begin
      wr(rows[i].addr, rows[i].wdata);
      rd_check(rows[i].addr, rows[i].exp);
    end
    // A second reset in mid-run must clear every register.
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 32; a += 4)
      rd_check(8'(a), 32'h0);
    settle(1);
    check(bottom, 32'h1);
    check(irq, 32'h0);
    // Stopped timer holds the written count.
    wr(OFF_COUNT, 32'h10);
    repeat (20) @(posedge clk);
    rd_check(OFF_COUNT, 32'h10);
    // Normal mode wraps at all ones and raises overflow.
    wr(OFF_COMPARE_A, 32'h80);
    wr(OFF_COMPARE_B, 32'h80);
    wr(OFF_COUNT, 32'hfd);
    wr(OFF_CONTROL_B, {29'h0, CS_EXT_RISE});
    pulse(2);
    settle(1);
    check(max_hit, 32'h1);
    rd_check(OFF_COUNT, 32'hff);
    pulse(1);
    rd_check(OFF_COUNT, 32'h0);
    settle(1);
    check(bottom, 32'h1);
    check(irq, 32'h0);
    rd_check(OFF_FLAG, 32'h1);
    wr(OFF_MASK, 32'h1);
    settle(3);
    check(irq, 32'h1);
    wr(OFF_FLAG, 32'h1);
    settle(3);
    check(irq, 32'h0);
    wr(OFF_MASK, 32'h0);
    // Falling edge selection ignores the rising edge.
    wr(OFF_CONTROL_B, {29'h0, CS_EXT_FALL});
    wr(OFF_COUNT, 32'h0);
    @(posedge clk);
    ext_pin <= 1'b1;
    repeat (10) @(posedge clk);
    rd_check(OFF_COUNT, 32'h0);
    ext_pin <= 1'b0;
    repeat (10) @(posedge clk);
    rd_check(OFF_COUNT, 32'h1);
    // Clear on compare A match, with compare A acting as top.
    wr(OFF_CONTROL_B, {29'h0, CS_STOP});
    wr(OFF_CONTROL_A, {30'h0, MODE_CTC[1:0]});
    wr(OFF_COMPARE_A, 32'h3);
    wr(OFF_COUNT, 32'h0);
    wr(OFF_FLAG, 32'h7);
    wr(OFF_CONTROL_B, {29'h0, CS_EXT_RISE});
    pulse(3);
    rd_check(OFF_COUNT, 32'h3);
    settle(1);
    check(top, 32'h1);
    check(match_a, 32'h1);
    pulse(1);
    rd_check(OFF_COUNT, 32'h0);
    rd_check(OFF_FLAG, 32'h2);
    // Power-off bit freezes the counter until cleared.
    wr(OFF_CONTROL_A, 32'h0);
    wr(OFF_POWER, 32'h1);
    wr(OFF_COUNT, 32'h20);
    pulse(2);
    rd_check(OFF_COUNT, 32'h20);
    wr(OFF_POWER, 32'h0);
    pulse(1);
    rd_check(OFF_COUNT, 32'h21);
    // Buffered compare write is not active until top in a PWM mode.
    wr(OFF_CONTROL_B, {29'h0, CS_STOP});
    wr(OFF_CONTROL_A, {30'h0, MODE_FAST_FF[1:0]});
    wr(OFF_COUNT, 32'h40);
    wr(OFF_COMPARE_B, 32'h40);
    settle(3);
    check(match_b, 32'h0);
    wr(OFF_CONTROL_A, 32'h0);
    wr(OFF_COMPARE_B, 32'h40);
    settle(3);
    check(match_b, 32'h1);
    // Each prescaler tap gives one tick per period over a whole number of periods.
    timed_run(CS_DIV1, 60, 32'h40);
    timed_run(CS_DIV8, 60, 32'h8);
    timed_run(CS_DIV64, 124, 32'h2);
    timed_run(CS_DIV256, 508, 32'h2);
    timed_run(CS_DIV1024, 1020, 32'h1);
    // Fast mode with top from compare A raises all three flags in one lap.
    wr(OFF_CONTROL_B, {29'h0, CS_STOP});
    wr(OFF_POWER, 32'h0);
    wr(OFF_COMPARE_A, 32'h2);
    wr(OFF_COMPARE_B, 32'h1);
    wr(OFF_CONTROL_A, {30'h0, MODE_FAST_OCRA[1:0]});
    wr(OFF_COUNT, 32'h0);
    wr(OFF_FLAG, 32'h7);
    wr(OFF_MASK, 32'h4);
    wr(OFF_CONTROL_B, {28'h0, MODE_FAST_OCRA[2], CS_EXT_RISE});
    pulse(3);
    rd_check(OFF_COUNT, 32'h0);
    rd_check(OFF_FLAG, 32'h7);
    check(irq, 32'h1);
    // Phase correct mode turns at all ones, loads the compare B buffer at the
    // turn, and raises overflow when it leaves the bottom.
    wr(OFF_CONTROL_B, {29'h0, CS_STOP});
    wr(OFF_CONTROL_A, {30'h0, MODE_PC_FF[1:0]});
    wr(OFF_COUNT, 32'hfe);
    wr(OFF_COMPARE_B, 32'hfd);
    wr(OFF_CONTROL_B, {29'h0, CS_EXT_RISE});
    pulse(2);
    rd_check(OFF_COUNT, 32'hfe);
    pulse(1);
    settle(1);
    check(match_b, 32'h1);
    wr(OFF_FLAG, 32'h7);
    wr(OFF_COUNT, 32'h1);
    pulse(2);
    rd_check(OFF_COUNT, 32'h1);
    rd_check(OFF_FLAG, 32'h1);
    tally_and_finish();
  end
endmodule
